/* File: rtl/misc_ctrl_pkg.sv */
package misc_ctrl_pkg;

  localparam logic [15:0] MISC_ONE_OFFSET = 16'h0020;
  localparam logic [15:0] MISC_TWO_OFFSET = 16'h0040;
  localparam logic [15:0] IRQ_STATUS_OFFSET = 16'h0060;
  localparam logic [15:0] IRQ_MASK_OFFSET = 16'h0061;

  localparam logic [7:0] MISC_ONE_RESET = 8'h00;
  localparam logic [7:0] MISC_TWO_RESET = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // misc_control_one fields
  localparam int PORTB_SEL_MSB = 7;
  localparam int PORTB_SEL_LSB = 6;
  localparam int CLOCK_OUT_BIT = 5;
  localparam int PORTA_SEL_MSB = 4;
  localparam int PORTA_SEL_LSB = 3;
  localparam int SLOW_DIV_MSB = 2;
  localparam int SLOW_DIV_LSB = 1;
  localparam int SLOW_MODE_BIT = 0;

  // misc_control_two fields
  localparam logic [7:0] MISC_TWO_USED_MASK = 8'h1f;
  localparam int SERIAL_OUT_DIS_BIT = 4;
  localparam int PWM_CH1_ROUTE_BIT = 3;
  localparam int PWM_CH0_ROUTE_BIT = 2;
  localparam int SS_SOURCE_BIT = 1;
  localparam int SS_INTERNAL_BIT = 0;

  // irq status / mask fields
  localparam logic [7:0] IRQ_USED_MASK = 8'h03;
  localparam int IRQ_PORTA_BIT = 0;
  localparam int IRQ_PORTB_BIT = 1;

  localparam int LINES = 8;
  localparam int DIV_CNT_W = 5;

  typedef enum logic [1:0] {
    TRIG_FALL_LOW = 2'b00,
    TRIG_RISE = 2'b01,
    TRIG_FALL = 2'b10,
    TRIG_BOTH = 2'b11
  } trig_mode_t;

  // slow divider code: bit2 is the msb, bit1 the lsb
  typedef enum logic [1:0] {
    SLOW_DIV4 = 2'b00,
    SLOW_DIV16 = 2'b01,
    SLOW_DIV8 = 2'b10,
    SLOW_DIV32 = 2'b11
  } slow_div_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic mosi;
    logic miso;
    logic sck;
  } spi_sig_t;

  typedef struct packed {
    logic normal_pin;
    logic normal_oe;
    logic resistive_pin;
    logic resistive_oe;
  } pwm_pins_t;

endpackage

/* File: rtl/ext_irq_detect.sv */
`timescale 1ns/1ps
module ext_irq_detect (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [misc_ctrl_pkg::LINES-1:0] lines,
  input wire logic [misc_ctrl_pkg::LINES-1:0] line_enable,
  input wire misc_ctrl_pkg::trig_mode_t mode,
  output logic request
);
  import misc_ctrl_pkg::*;

  typedef struct packed {
    logic [LINES-1:0] prev;
    logic primed;
    logic request;
  } det_state_t;

  det_state_t state_reg;
  det_state_t state_next;
  logic [LINES-1:0] rise;
  logic [LINES-1:0] fall;

  // no edge is seen on the first cycle after reset, so pulled-up lines cannot fire
  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_line
      assign rise[i] = state_reg.primed & line_enable[i] & lines[i] & ~state_reg.prev[i];
      assign fall[i] = state_reg.primed & line_enable[i] & ~lines[i] & state_reg.prev[i];
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    state_next.prev = lines;
    state_next.primed = 1'b1;
    unique case (mode)
      TRIG_FALL_LOW: state_next.request = (|fall) | (|(line_enable & ~lines));
      TRIG_RISE: state_next.request = |rise;
      TRIG_FALL: state_next.request = |fall;
      TRIG_BOTH: state_next.request = (|rise) | (|fall);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign request = state_reg.request;
endmodule

/* File: rtl/cpu_clock_divider.sv */
`timescale 1ns/1ps
module cpu_clock_divider (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic slow_mode,
  input wire misc_ctrl_pkg::slow_div_t slow_div,
  output logic cpu_clk,
  output logic cpu_tick,
  output logic osc_half
);
  import misc_ctrl_pkg::*;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] count;
    logic cpu_clk;
    logic cpu_tick;
    logic osc_half;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;
  logic [DIV_CNT_W-1:0] count_inc;
  logic [2:0] tap;

  // a free-running counter keeps every ratio phase-related, but a ratio change moves the tap at once and can cut a cpu_clk phase short
  always_comb begin
    count_inc = state_reg.count + 5'h01;
    tap = 3'h0;
    if (slow_mode) begin
      unique case (slow_div)
        SLOW_DIV4: tap = 3'h1;
        SLOW_DIV8: tap = 3'h2;
        SLOW_DIV16: tap = 3'h3;
        SLOW_DIV32: tap = 3'h4;
      endcase
    end
    state_next = state_reg;
    state_next.count = count_inc;
    state_next.cpu_clk = count_inc[tap];
    state_next.cpu_tick = count_inc[tap] & ~state_reg.cpu_clk;
    state_next.osc_half = count_inc[0];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cpu_clk = state_reg.cpu_clk;
  assign cpu_tick = state_reg.cpu_tick;
  assign osc_half = state_reg.osc_half;
endmodule

/* File: rtl/misc_control_registers.sv */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module misc_control_registers (
  input wire logic core_clk,
  input wire logic srst,
  input wire misc_ctrl_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [misc_ctrl_pkg::LINES-1:0] porta_lines,
  input wire logic [misc_ctrl_pkg::LINES-1:0] porta_line_enable,
  input wire logic [misc_ctrl_pkg::LINES-1:0] portb_lines,
  input wire logic [misc_ctrl_pkg::LINES-1:0] portb_line_enable,
  output logic porta_ext_irq,
  output logic portb_ext_irq,
  output logic irq,
  output logic cpu_clk,
  output logic cpu_tick,
  input wire logic clock_out_gpio_value,
  input wire logic clock_out_gpio_oe,
  output logic clock_out_pin,
  output logic clock_out_oe,
  output logic clock_out_enable,
  input wire misc_ctrl_pkg::spi_sig_t spi_out,
  input wire misc_ctrl_pkg::spi_sig_t spi_out_oe,
  output misc_ctrl_pkg::spi_sig_t spi_pin_out,
  output misc_ctrl_pkg::spi_sig_t spi_pin_oe,
  output logic serial_out_disable,
  input wire logic slave_select_pin_n,
  output logic spi_slave_select_n,
  input wire logic pwm_ch0,
  input wire logic pwm_ch0_enable,
  input wire logic pwm_ch1,
  input wire logic pwm_ch1_enable,
  output misc_ctrl_pkg::pwm_pins_t pwm_ch0_pins,
  output misc_ctrl_pkg::pwm_pins_t pwm_ch1_pins
);
  import misc_ctrl_pkg::*;

  typedef struct packed {
    logic [7:0] misc_control_one;
    logic [7:0] misc_control_two;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic clock_out_pin;
    logic clock_out_oe;
    spi_sig_t spi_pin_out;
    spi_sig_t spi_pin_oe;
    logic slave_select_n;
    pwm_pins_t pwm_ch0_pins;
    pwm_pins_t pwm_ch1_pins;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  trig_mode_t porta_irq_trigger_sel;
  trig_mode_t portb_irq_trigger_sel;
  slow_div_t slow_clock_divider;
  logic slow_mode_select;
  logic clock_out_sel;
  logic pwm_ch1_route;
  logic pwm_ch0_route;
  logic slave_select_source;
  logic slave_select_internal_value;
  logic osc_half;
  logic [7:0] irq_events;
  logic wr_one;
  logic wr_two;
  logic wr_status;
  logic wr_mask;

  // field views of the control registers
  assign portb_irq_trigger_sel = trig_mode_t'(state_reg.misc_control_one[PORTB_SEL_MSB:PORTB_SEL_LSB]);
  assign porta_irq_trigger_sel = trig_mode_t'(state_reg.misc_control_one[PORTA_SEL_MSB:PORTA_SEL_LSB]);
  assign clock_out_sel = state_reg.misc_control_one[CLOCK_OUT_BIT];
  assign slow_clock_divider = slow_div_t'(state_reg.misc_control_one[SLOW_DIV_MSB:SLOW_DIV_LSB]);
  assign slow_mode_select = state_reg.misc_control_one[SLOW_MODE_BIT];
  assign serial_out_disable = state_reg.misc_control_two[SERIAL_OUT_DIS_BIT];
  assign pwm_ch1_route = state_reg.misc_control_two[PWM_CH1_ROUTE_BIT];
  assign pwm_ch0_route = state_reg.misc_control_two[PWM_CH0_ROUTE_BIT];
  assign slave_select_source = state_reg.misc_control_two[SS_SOURCE_BIT];
  assign slave_select_internal_value = state_reg.misc_control_two[SS_INTERNAL_BIT];

  ext_irq_detect u_porta_detect (
    .core_clk(core_clk),
    .srst(srst),
    .lines(porta_lines),
    .line_enable(porta_line_enable),
    .mode(porta_irq_trigger_sel),
    .request(porta_ext_irq)
  );

  ext_irq_detect u_portb_detect (
    .core_clk(core_clk),
    .srst(srst),
    .lines(portb_lines),
    .line_enable(portb_line_enable),
    .mode(portb_irq_trigger_sel),
    .request(portb_ext_irq)
  );

  cpu_clock_divider u_cpu_div (
    .core_clk(core_clk),
    .srst(srst),
    .slow_mode(slow_mode_select),
    .slow_div(slow_clock_divider),
    .cpu_clk(cpu_clk),
    .cpu_tick(cpu_tick),
    .osc_half(osc_half)
  );

  always_comb begin
    wr_one = reg_req.wr & (reg_req.addr == MISC_ONE_OFFSET);
    wr_two = reg_req.wr & (reg_req.addr == MISC_TWO_OFFSET);
    wr_status = reg_req.wr & (reg_req.addr == IRQ_STATUS_OFFSET);
    wr_mask = reg_req.wr & (reg_req.addr == IRQ_MASK_OFFSET);
    irq_events = 8'h00;
    irq_events[IRQ_PORTA_BIT] = porta_ext_irq;
    irq_events[IRQ_PORTB_BIT] = portb_ext_irq;

    state_next = state_reg;

    // register writes
    if (wr_one) begin
      state_next.misc_control_one = reg_req.wdata;
    end
    if (wr_two) begin
      state_next.misc_control_two = reg_req.wdata & MISC_TWO_USED_MASK;
    end
    if (wr_mask) begin
      state_next.irq_mask = reg_req.wdata & IRQ_USED_MASK;
    end
    // a request in the clearing cycle survives: set wins over write-one-to-clear
    if (wr_status) begin
      state_next.irq_status = state_reg.irq_status & ~reg_req.wdata;
    end
    state_next.irq_status = state_next.irq_status | irq_events;

    // read data stand in the cycle after the strobe only
    state_next.rdata = 8'h00;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        MISC_ONE_OFFSET: state_next.rdata = state_reg.misc_control_one;
        MISC_TWO_OFFSET: state_next.rdata = state_reg.misc_control_two;
        IRQ_STATUS_OFFSET: state_next.rdata = state_reg.irq_status;
        IRQ_MASK_OFFSET: state_next.rdata = state_reg.irq_mask;
        default: state_next.rdata = 8'h00;
      endcase
    end

    // clock output: alternate function takes the pin over general I/O
    if (clock_out_sel) begin
      state_next.clock_out_pin = osc_half;
      state_next.clock_out_oe = 1'b1;
    end else begin
      state_next.clock_out_pin = clock_out_gpio_value;
      state_next.clock_out_oe = clock_out_gpio_oe;
    end

    // serial outputs; pin values still follow so that only the enable decides ownership
    state_next.spi_pin_out = spi_out;
    state_next.spi_pin_oe = serial_out_disable ? 3'b000 : spi_out_oe;

    // slave select source
    state_next.slave_select_n = slave_select_source ? slave_select_internal_value : slave_select_pin_n;

    // pwm routing; only the selected pin is driven, the other is released
    state_next.pwm_ch0_pins.normal_pin = pwm_ch0 & ~pwm_ch0_route;
    state_next.pwm_ch0_pins.normal_oe = pwm_ch0_enable & ~pwm_ch0_route;
    state_next.pwm_ch0_pins.resistive_pin = pwm_ch0 & pwm_ch0_route;
    state_next.pwm_ch0_pins.resistive_oe = pwm_ch0_enable & pwm_ch0_route;
    state_next.pwm_ch1_pins.normal_pin = pwm_ch1 & ~pwm_ch1_route;
    state_next.pwm_ch1_pins.normal_oe = pwm_ch1_enable & ~pwm_ch1_route;
    state_next.pwm_ch1_pins.resistive_pin = pwm_ch1 & pwm_ch1_route;
    state_next.pwm_ch1_pins.resistive_oe = pwm_ch1_enable & pwm_ch1_route;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.misc_control_one <= MISC_ONE_RESET;
      state_reg.misc_control_two <= MISC_TWO_RESET;
      state_reg.irq_status <= IRQ_STATUS_RESET;
      state_reg.irq_mask <= IRQ_MASK_RESET;
      state_reg.slave_select_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign irq = |(state_reg.irq_status & state_reg.irq_mask);
  assign clock_out_enable = clock_out_sel;
  assign clock_out_pin = state_reg.clock_out_pin;
  assign clock_out_oe = state_reg.clock_out_oe;
  assign spi_pin_out = state_reg.spi_pin_out;
  assign spi_pin_oe = state_reg.spi_pin_oe;
  assign spi_slave_select_n = state_reg.slave_select_n;
  assign pwm_ch0_pins = state_reg.pwm_ch0_pins;
  assign pwm_ch1_pins = state_reg.pwm_ch1_pins;
endmodule

/* File: dv/misc_ctrl_properties.sv */
`timescale 1ns/1ps
module misc_ctrl_checker (
  input wire logic core_clk,
  input wire logic srst,
  input wire misc_ctrl_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic porta_ext_irq,
  input wire logic portb_ext_irq,
  input wire logic cpu_tick,
  input wire logic clock_out_gpio_value,
  input wire logic clock_out_gpio_oe,
  input wire logic clock_out_pin,
  input wire logic clock_out_oe,
  input wire logic clock_out_enable,
  input wire misc_ctrl_pkg::spi_sig_t spi_out_oe,
  input wire misc_ctrl_pkg::spi_sig_t spi_pin_oe,
  input wire logic serial_out_disable,
  input wire logic pwm_ch0_enable,
  input wire misc_ctrl_pkg::pwm_pins_t pwm_ch0_pins,
  input wire misc_ctrl_pkg::pwm_pins_t pwm_ch1_pins
);
  import misc_ctrl_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_clkout_oe: assert property (clock_out_enable |=> clock_out_oe)
    else $error("clock out not driven");
  a_clkout_toggle: assert property (clock_out_enable [*2] |=> clock_out_pin != $past(clock_out_pin))
    else $error("clock out not toggling");
  a_clkout_gpio: assert property (!clock_out_enable |=>
    clock_out_pin == $past(clock_out_gpio_value) && clock_out_oe == $past(clock_out_gpio_oe))
    else $error("clock pin not general io");
  a_spi_off: assert property (serial_out_disable |=> spi_pin_oe == 3'b000)
    else $error("serial pins driven while disabled");
  a_spi_on: assert property (!serial_out_disable |=> spi_pin_oe == $past(spi_out_oe))
    else $error("serial enables not passed");
  a_pwm_released: assert property (!pwm_ch0_enable |=> (pwm_ch0_pins.normal_oe | pwm_ch0_pins.resistive_oe) == 1'b0)
    else $error("pwm0 pin driven while off");
  a_pwm_one_pin: assert property (!(pwm_ch1_pins.normal_oe && pwm_ch1_pins.resistive_oe))
    else $error("pwm1 on both pins");
  a_tick_gap: assert property (cpu_tick |=> !cpu_tick)
    else $error("cpu tick too fast");
  a_irq_cause: assert property ($rose(irq) |-> $past(porta_ext_irq) || $past(portb_ext_irq) || $past(reg_req.wr))
    else $error("irq without cause");
endmodule
bind misc_control_registers misc_ctrl_checker u_misc_ctrl_checker (.core_clk, .srst, .reg_req, .reg_rdata,
  .irq, .porta_ext_irq, .portb_ext_irq, .cpu_tick, .clock_out_gpio_value, .clock_out_gpio_oe, .clock_out_pin,
  .clock_out_oe, .clock_out_enable, .spi_out_oe, .spi_pin_oe, .serial_out_disable, .pwm_ch0_enable,
  .pwm_ch0_pins, .pwm_ch1_pins);

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import misc_ctrl_pkg::*;
  logic core_clk = 0;
  logic srst = 1;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic [LINES-1:0] porta_lines = '1, porta_line_enable = '0, portb_lines = '1, portb_line_enable = '0;
  logic porta_ext_irq, portb_ext_irq, irq, cpu_clk, cpu_tick, clock_out_pin, clock_out_oe, clock_out_enable;
  logic clock_out_gpio_value = 1, clock_out_gpio_oe = 1, slave_select_pin_n = 1;
  spi_sig_t spi_out = 3'b101, spi_out_oe = 3'b111, spi_pin_out, spi_pin_oe;
  logic serial_out_disable, spi_slave_select_n;
  logic pwm_ch0 = 1, pwm_ch0_enable = 1, pwm_ch1 = 1, pwm_ch1_enable = 1;
  pwm_pins_t pwm_ch0_pins, pwm_ch1_pins;
  int errors = 0, n_tests = 0;
  misc_control_registers u_misc_control_registers (.core_clk, .srst, .reg_req, .reg_rdata, .porta_lines,
    .porta_line_enable, .portb_lines, .portb_line_enable, .porta_ext_irq, .portb_ext_irq, .irq, .cpu_clk,
    .cpu_tick, .clock_out_gpio_value, .clock_out_gpio_oe, .clock_out_pin, .clock_out_oe, .clock_out_enable,
    .spi_out, .spi_out_oe, .spi_pin_out, .spi_pin_oe, .serial_out_disable, .slave_select_pin_n,
    .spi_slave_select_n, .pwm_ch0, .pwm_ch0_enable, .pwm_ch1, .pwm_ch1_enable, .pwm_ch0_pins, .pwm_ch1_pins);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // wait n edges, then let their updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic t_regs;
    rd(MISC_ONE_OFFSET, 8'h00);
    chk({6'h0, spi_slave_select_n, irq}, 8'h02);
    rd(MISC_TWO_OFFSET, 8'h00);
    wr(MISC_ONE_OFFSET, 8'hff);
    rd(MISC_ONE_OFFSET, 8'hff);
    wr(MISC_TWO_OFFSET, 8'hff);
    rd(MISC_TWO_OFFSET, 8'h1f);
    wr(16'h0021, 8'h55);
    rd(16'h0021, 8'h00);
    wr(MISC_ONE_OFFSET, 8'h00);
    wr(MISC_TWO_OFFSET, 8'h00);
    rd(MISC_ONE_OFFSET, 8'h00);
    $display("regs test done");
  endtask
  task automatic t_clk;
    logic [7:0] cfg [6] = '{8'h00, 8'h06, 8'h01, 8'h05, 8'h03, 8'h07};
    logic [7:0] per [6] = '{8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
    int n;
    for (int i = 0; i < 6; i++) begin
      wr(MISC_ONE_OFFSET, cfg[i]);
      cyc(40);
      while (cpu_tick !== 1'b1) cyc(1);
      chk({7'h0, cpu_clk}, 8'h01);
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (cpu_tick !== 1'b1 && n < 64);
      chk(n[7:0], per[i]);
    end
    $display("clock test done");
  endtask
  task automatic t_irq;
    logic [7:0] exp [4] = '{8'h06, 8'h01, 8'h01, 8'h02};
    int n;
    wr(IRQ_MASK_OFFSET, 8'h03);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wr(MISC_ONE_OFFSET, p ? {m[1:0], 6'h00} : {3'b000, m[1:0], 3'b000});
        n = 0;
        // line 0 low for six cycles, then high again
        for (int c = 0; c < 12; c++) begin
          @(posedge core_clk);
          if (p)
            portb_lines[0] <= (c >= 6);
          else
            porta_lines[0] <= (c >= 6);
          #1 n += p ? portb_ext_irq : porta_ext_irq;
        end
        chk(n[7:0], exp[m]);
        rd(IRQ_STATUS_OFFSET, p ? 8'h02 : 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr(IRQ_MASK_OFFSET, 8'h00);
        cyc(1);
        chk({7'h0, irq}, 8'h00);
        wr(IRQ_MASK_OFFSET, 8'h03);
        wr(IRQ_STATUS_OFFSET, 8'h03);
        cyc(1);
        chk({7'h0, irq}, 8'h00);
      end
    end
    $display("irq test done");
  endtask
  task automatic t_pins;
    wr(MISC_ONE_OFFSET, 8'h20);
    cyc(2);
    chk({6'h0, clock_out_enable, clock_out_oe}, 8'h03);
    wr(MISC_ONE_OFFSET, 8'h00);
    cyc(2);
    chk({6'h0, clock_out_oe, clock_out_pin}, 8'h03);
    wr(MISC_TWO_OFFSET, 8'h10);
    cyc(2);
    chk({2'h0, spi_pin_oe, spi_pin_out}, 8'h05);
    wr(MISC_TWO_OFFSET, 8'h0e); // port c pins driven by the serial outputs here
    cyc(2);
    chk({2'h0, spi_pin_oe, spi_pin_out}, 8'h3d);
    chk({7'h0, spi_slave_select_n}, 8'h00);
    chk({pwm_ch0_pins, pwm_ch1_pins}, 8'h33);
    @(posedge core_clk);
    pwm_ch0_enable <= 1'b0;
    pwm_ch1 <= 1'b0;
    slave_select_pin_n <= 1'b0;
    cyc(2);
    chk({pwm_ch0_pins, pwm_ch1_pins}, 8'h21);
    @(posedge core_clk);
    pwm_ch0_enable <= 1'b1;
    pwm_ch1 <= 1'b1;
    wr(MISC_TWO_OFFSET, 8'h01);
    cyc(2);
    chk({7'h0, spi_slave_select_n}, 8'h00);
    chk({pwm_ch0_pins, pwm_ch1_pins}, 8'hcc);
    wr(MISC_TWO_OFFSET, 8'h03);
    cyc(2);
    chk({7'h0, spi_slave_select_n}, 8'h01);
    $display("pins test done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // the tests need about 650 cycles; thirty times that means a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    porta_line_enable <= 8'h01;
    portb_line_enable <= 8'h01;
    t_regs;
    t_clk;
    t_irq;
    t_pins;
    finish_test;
  end
endmodule
